// ---- design/dtc_phase.sv ----
`timescale 1ns/1ns
module dtc_phase #(
	parameter int MC_CLOCKS    = dtc_pkg::MC_CLOCKS,
	parameter int SAMPLE_PHASE = dtc_pkg::SAMPLE_PHASE,
	parameter int UPDATE_PHASE = dtc_pkg::UPDATE_PHASE
) (
	input  wire logic ref_clk,
	input  wire logic reset,
	output logic      sample_pulse,
	output logic      update_pulse
);

	localparam int PW = $clog2(MC_CLOCKS);

	logic [PW-1:0] phase;

	// one machine cycle is MC_CLOCKS core clocks
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			phase <= '0;
		end else if (phase == PW'(MC_CLOCKS - 1)) begin
			phase <= '0;
		end else begin
			phase <= phase + PW'(1);
		end
	end

	// pulses are registered so each lands exactly once per machine cycle
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sample_pulse <= 1'b0;
			update_pulse <= 1'b0;
		end else begin
			sample_pulse <= (phase == PW'(SAMPLE_PHASE));
			update_pulse <= (phase == PW'(UPDATE_PHASE));
		end
	end

endmodule : dtc_phase

// ---- design/dtc_pkg.sv ----
package dtc_pkg;

	// register addresses on the special function register port
	localparam logic [7:0] ADDR_TIMER_CTL   = 8'h88;
	localparam logic [7:0] ADDR_TIMER_MODE  = 8'h89;
	localparam logic [7:0] ADDR_FIRST_LOW   = 8'h8A;
	localparam logic [7:0] ADDR_SECOND_LOW  = 8'h8B;
	localparam logic [7:0] ADDR_FIRST_HIGH  = 8'h8C;
	localparam logic [7:0] ADDR_SECOND_HIGH = 8'h8D;

	// reset values
	localparam logic [7:0] TIMER_MODE_RESET = 8'h00;
	localparam logic [7:0] TIMER_CTL_RESET  = 8'h00;
	localparam logic [7:0] COUNT_RESET      = 8'h00;

	// mode register field positions
	localparam int MODE_SECOND_GATE_BIT = 7;
	localparam int MODE_SECOND_SRC_BIT  = 6;
	localparam int MODE_SECOND_SEL_HI   = 5;
	localparam int MODE_SECOND_SEL_LO   = 4;
	localparam int MODE_FIRST_GATE_BIT  = 3;
	localparam int MODE_FIRST_SRC_BIT   = 2;
	localparam int MODE_FIRST_SEL_HI    = 1;
	localparam int MODE_FIRST_SEL_LO    = 0;

	// control register field positions
	localparam int CTL_SECOND_OVF_BIT = 7;
	localparam int CTL_SECOND_RUN_BIT = 6;
	localparam int CTL_FIRST_OVF_BIT  = 5;
	localparam int CTL_FIRST_RUN_BIT  = 4;

	// machine cycle timing, in core clocks; clock period in ns
	localparam int MC_CLOCKS     = 12;
	localparam int CLK_PERIOD_NS = 20;
	localparam int SAMPLE_PHASE  = 9;
	localparam int UPDATE_PHASE  = 4;

	// width of the prescaler in the 13-bit mode
	localparam int PRESCALE_BITS = 5;

	typedef enum logic [1:0] {
		DTC_MODE_13BIT,
		DTC_MODE_16BIT,
		DTC_MODE_RELOAD,
		DTC_MODE_SPLIT
	} dtc_mode_t;

	typedef struct packed {
		logic [7:0] high_byte;
		logic [7:0] low_byte;
	} dtc_count_t;

	typedef struct packed {
		logic       ovf;
		dtc_count_t cnt;
	} dtc_step_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dtc_sfr_req_t;

endpackage : dtc_pkg

// ---- design/dtc_top.sv ----
`timescale 1ns/1ns
module dtc_top (
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_addr,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	input  wire logic       first_count_pin,
	input  wire logic       second_count_pin,
	input  wire logic       first_gate_pin,
	input  wire logic       second_gate_pin,
	input  wire logic       first_vector_ack,
	input  wire logic       second_vector_ack,
	output logic            first_overflow_flag,
	output logic            second_overflow_flag
);

	dtc_pkg::dtc_sfr_req_t req;
	logic [7:0]            timer_mode_register;
	logic                  first_run_bit;
	logic                  second_run_bit;
	dtc_pkg::dtc_count_t   first_cnt;
	dtc_pkg::dtc_count_t   second_cnt;
	dtc_pkg::dtc_count_t   next_first_cnt;
	dtc_pkg::dtc_count_t   next_second_cnt;
	dtc_pkg::dtc_step_t    first_step;
	dtc_pkg::dtc_step_t    second_step;
	dtc_pkg::dtc_mode_t    first_mode;
	dtc_pkg::dtc_mode_t    second_mode;
	logic                  sample_pulse;
	logic                  update_pulse;
	logic                  first_last_sample;
	logic                  second_last_sample;
	logic                  first_edge_pending;
	logic                  second_edge_pending;
	logic                  first_tick;
	logic                  second_tick;
	logic                  first_enable;
	logic                  second_enable;
	logic                  first_ovf_event;
	logic                  second_ovf_event;
	logic                  split_ovf_event;
	logic                  first_split_ovf;
	logic                  ctl_write;

	// 9-bit result: carry in bit 8
	function automatic logic [8:0] inc8(input logic [7:0] v);
		inc8 = {1'b0, v} + 9'h001;
	endfunction : inc8

	// one count step for a timer in a non-split mode
	function automatic dtc_pkg::dtc_step_t step(
		input dtc_pkg::dtc_mode_t  mode,
		input dtc_pkg::dtc_count_t c
	);
		logic [5:0] pre;
		logic [8:0] hi;
		logic [8:0] lo;
		step = '{ovf: 1'b0, cnt: c};
		pre  = '0;
		hi   = '0;
		lo   = '0;
		unique case (mode)
			dtc_pkg::DTC_MODE_13BIT: begin
				// upper three low-byte bits are not part of the count
				pre = {1'b0, c.low_byte[dtc_pkg::PRESCALE_BITS-1:0]} + 6'h01;
				step.cnt.low_byte[dtc_pkg::PRESCALE_BITS-1:0] = pre[4:0];
				if (pre[dtc_pkg::PRESCALE_BITS]) begin
					hi                 = inc8(c.high_byte);
					step.cnt.high_byte = hi[7:0];
					step.ovf           = hi[8];
				end
			end
			dtc_pkg::DTC_MODE_16BIT: begin
				lo                = inc8(c.low_byte);
				step.cnt.low_byte = lo[7:0];
				if (lo[8]) begin
					hi                 = inc8(c.high_byte);
					step.cnt.high_byte = hi[7:0];
					step.ovf           = hi[8];
				end
			end
			dtc_pkg::DTC_MODE_RELOAD: begin
				lo       = inc8(c.low_byte);
				step.ovf = lo[8];
				// reload leaves the high byte untouched
				step.cnt.low_byte = lo[8] ? c.high_byte : lo[7:0];
			end
			dtc_pkg::DTC_MODE_SPLIT: begin
				step.ovf = 1'b0;
			end
		endcase
	endfunction : step

	assign req = '{wr: sfr_wr, rd: sfr_rd, addr: sfr_addr, wdata: sfr_wdata};

	dtc_phase u_phase (
		.ref_clk      (ref_clk),
		.reset        (reset),
		.sample_pulse (sample_pulse),
		.update_pulse (update_pulse)
	);

	assign first_mode  = dtc_pkg::dtc_mode_t'(timer_mode_register[dtc_pkg::MODE_FIRST_SEL_HI:
		dtc_pkg::MODE_FIRST_SEL_LO]);
	assign second_mode = dtc_pkg::dtc_mode_t'(timer_mode_register[dtc_pkg::MODE_SECOND_SEL_HI:
		dtc_pkg::MODE_SECOND_SEL_LO]);

	assign ctl_write = req.wr && (req.addr == dtc_pkg::ADDR_TIMER_CTL);

	// mode register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			timer_mode_register <= dtc_pkg::TIMER_MODE_RESET;
		end else if (req.wr && req.addr == dtc_pkg::ADDR_TIMER_MODE) begin
			timer_mode_register <= req.wdata;
		end
	end

	// run bits
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			first_run_bit  <= dtc_pkg::TIMER_CTL_RESET[dtc_pkg::CTL_FIRST_RUN_BIT];
			second_run_bit <= dtc_pkg::TIMER_CTL_RESET[dtc_pkg::CTL_SECOND_RUN_BIT];
		end else if (ctl_write) begin
			first_run_bit  <= req.wdata[dtc_pkg::CTL_FIRST_RUN_BIT];
			second_run_bit <= req.wdata[dtc_pkg::CTL_SECOND_RUN_BIT];
		end
	end

	// pin edge detection; pins rely on the source holding each level a full
	// machine cycle, shorter pulses may fall between two samples
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			first_last_sample  <= 1'b0;
			second_last_sample <= 1'b0;
		end else if (sample_pulse) begin
			first_last_sample  <= first_count_pin;
			second_last_sample <= second_count_pin;
		end
	end

	// sample and update phases never coincide, so pending set and use are apart
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			first_edge_pending  <= 1'b0;
			second_edge_pending <= 1'b0;
		end else if (sample_pulse) begin
			first_edge_pending  <= first_last_sample && !first_count_pin;
			second_edge_pending <= second_last_sample && !second_count_pin;
		end else if (update_pulse) begin
			first_edge_pending  <= 1'b0;
			second_edge_pending <= 1'b0;
		end
	end

	// source select: machine cycle or pin edge, both landing on the update phase
	assign first_tick = timer_mode_register[dtc_pkg::MODE_FIRST_SRC_BIT] ?
		(first_edge_pending && update_pulse) : update_pulse;
	assign second_tick = timer_mode_register[dtc_pkg::MODE_SECOND_SRC_BIT] ?
		(second_edge_pending && update_pulse) : update_pulse;

	assign first_enable = first_run_bit &&
		(!timer_mode_register[dtc_pkg::MODE_FIRST_GATE_BIT] || first_gate_pin);
	assign second_enable = second_run_bit &&
		(!timer_mode_register[dtc_pkg::MODE_SECOND_GATE_BIT] || second_gate_pin);

	assign first_step  = step(first_mode, first_cnt);
	assign second_step = step(second_mode, second_cnt);

	// first timer next value
	always_comb begin
		logic [8:0] lo;
		logic [8:0] hi;
		lo              = inc8(first_cnt.low_byte);
		hi              = inc8(first_cnt.high_byte);
		next_first_cnt  = first_cnt;
		first_ovf_event = 1'b0;
		split_ovf_event = 1'b0;
		if (first_mode == dtc_pkg::DTC_MODE_SPLIT) begin
			if (first_enable && first_tick) begin
				next_first_cnt.low_byte = lo[7:0];
				first_ovf_event         = lo[8];
			end
			// high byte only counts machine cycles, under the second run bit
			if (second_run_bit && update_pulse) begin
				next_first_cnt.high_byte = hi[7:0];
				split_ovf_event          = hi[8];
			end
		end else if (first_enable && first_tick) begin
			next_first_cnt  = first_step.cnt;
			first_ovf_event = first_step.ovf;
		end
		// a byte write takes precedence over a count in the same clock
		if (req.wr && req.addr == dtc_pkg::ADDR_FIRST_LOW) begin
			next_first_cnt.low_byte = req.wdata;
		end
		if (req.wr && req.addr == dtc_pkg::ADDR_FIRST_HIGH) begin
			next_first_cnt.high_byte = req.wdata;
		end
	end

	// second timer next value
	always_comb begin
		next_second_cnt  = second_cnt;
		second_ovf_event = 1'b0;
		if (second_mode != dtc_pkg::DTC_MODE_SPLIT && second_enable && second_tick) begin
			next_second_cnt  = second_step.cnt;
			second_ovf_event = second_step.ovf;
		end
		if (req.wr && req.addr == dtc_pkg::ADDR_SECOND_LOW) begin
			next_second_cnt.low_byte = req.wdata;
		end
		if (req.wr && req.addr == dtc_pkg::ADDR_SECOND_HIGH) begin
			next_second_cnt.high_byte = req.wdata;
		end
	end

	// count bytes
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			first_cnt  <= '{high_byte: dtc_pkg::COUNT_RESET, low_byte: dtc_pkg::COUNT_RESET};
			second_cnt <= '{high_byte: dtc_pkg::COUNT_RESET, low_byte: dtc_pkg::COUNT_RESET};
		end else begin
			first_cnt  <= next_first_cnt;
			second_cnt <= next_second_cnt;
		end
	end

	// while split, the second timer's own overflow cannot reach its flag
	assign first_split_ovf = (first_mode == dtc_pkg::DTC_MODE_SPLIT) ? split_ovf_event :
		second_ovf_event;

	// overflow flags: a set in the clearing clock wins
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			first_overflow_flag <= dtc_pkg::TIMER_CTL_RESET[dtc_pkg::CTL_FIRST_OVF_BIT];
		end else if (first_ovf_event) begin
			first_overflow_flag <= 1'b1;
		end else if (ctl_write) begin
			first_overflow_flag <= req.wdata[dtc_pkg::CTL_FIRST_OVF_BIT];
		end else if (first_vector_ack) begin
			first_overflow_flag <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			second_overflow_flag <= dtc_pkg::TIMER_CTL_RESET[dtc_pkg::CTL_SECOND_OVF_BIT];
		end else if (first_split_ovf) begin
			second_overflow_flag <= 1'b1;
		end else if (ctl_write) begin
			second_overflow_flag <= req.wdata[dtc_pkg::CTL_SECOND_OVF_BIT];
		end else if (second_vector_ack) begin
			second_overflow_flag <= 1'b0;
		end
	end

	// registered read data; holds between reads, unmapped reads give zero
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sfr_rdata <= 8'h00;
		end else if (req.rd) begin
			unique case (req.addr)
				dtc_pkg::ADDR_TIMER_CTL: begin
					sfr_rdata <= {second_overflow_flag, second_run_bit,
						first_overflow_flag, first_run_bit, 4'h0};
				end
				dtc_pkg::ADDR_TIMER_MODE: begin
					sfr_rdata <= timer_mode_register;
				end
				dtc_pkg::ADDR_FIRST_LOW: begin
					sfr_rdata <= first_cnt.low_byte;
				end
				dtc_pkg::ADDR_FIRST_HIGH: begin
					sfr_rdata <= first_cnt.high_byte;
				end
				dtc_pkg::ADDR_SECOND_LOW: begin
					sfr_rdata <= second_cnt.low_byte;
				end
				dtc_pkg::ADDR_SECOND_HIGH: begin
					sfr_rdata <= second_cnt.high_byte;
				end
				default: begin
					sfr_rdata <= 8'h00;
				end
			endcase
		end
	end

endmodule : dtc_top

// ---- test/dtc_chk.sv ----
`timescale 1ns/1ns
module dtc_chk (
	input wire logic       ref_clk,
	input wire logic       reset,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic       first_vector_ack,
	input wire logic       second_vector_ack,
	input wire logic       first_overflow_flag,
	input wire logic       second_overflow_flag
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	wire logic ctl_a = sfr_addr == dtc_pkg::ADDR_TIMER_CTL;
	wire logic mod_a = sfr_addr == dtc_pkg::ADDR_TIMER_MODE;
	wire logic unmap = sfr_addr < 8'h88 || sfr_addr > 8'h8D;

	a_unmapped_read: assert property (sfr_rd && unmap |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_ctl_low_zero: assert property (sfr_rd && ctl_a |=> sfr_rdata[3:0] == 4'h0)
		else $error("control low bits not zero");
	a_flag_mirror: assert property (sfr_rd && ctl_a |=>
		sfr_rdata[7] == $past(second_overflow_flag) && sfr_rdata[5] == $past(first_overflow_flag))
		else $error("flag bits differ from flag outputs");
	a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_mode_readback: assert property (sfr_wr && mod_a ##1 !sfr_wr ##1
		sfr_rd && mod_a && !sfr_wr |=> sfr_rdata == $past(sfr_wdata, 3))
		else $error("mode readback differs");
	a_run_readback: assert property (sfr_wr && ctl_a ##1 !sfr_wr ##1
		sfr_rd && ctl_a && !sfr_wr |=> sfr_rdata[6] == $past(sfr_wdata[6], 3)
		&& sfr_rdata[4] == $past(sfr_wdata[4], 3))
		else $error("run bit readback differs");
	a_reset_clear: assert property ($fell(reset) |->
		!first_overflow_flag && !second_overflow_flag && sfr_rdata == 8'h00)
		else $error("outputs not clear after reset");
	a_first_flag_clear: assert property ($fell(first_overflow_flag) |->
		$past(first_vector_ack) || $past(reset) || $past(sfr_wr && ctl_a && !sfr_wdata[5]))
		else $error("first flag fell without cause");
	a_second_flag_clear: assert property ($fell(second_overflow_flag) |->
		$past(second_vector_ack) || $past(reset) || $past(sfr_wr && ctl_a && !sfr_wdata[7]))
		else $error("second flag fell without cause");

	c_first_ovf: cover property ($rose(first_overflow_flag));
	c_second_ovf: cover property ($rose(second_overflow_flag));
	c_ack: cover property (first_vector_ack && first_overflow_flag);
endmodule : dtc_chk

bind dtc_top dtc_chk chk_u (.ref_clk(ref_clk), .reset(reset), .sfr_wr(sfr_wr),
	.sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
	.first_vector_ack(first_vector_ack), .second_vector_ack(second_vector_ack),
	.first_overflow_flag(first_overflow_flag), .second_overflow_flag(second_overflow_flag));

// ---- test/dtc_pins.sv ----
`timescale 1ns/1ns
module dtc_pins (
	input  wire logic       ref_clk,
	input  wire logic       go,
	input  wire logic       sel,
	input  wire logic [7:0] edges,
	input  wire logic [7:0] hold,
	output logic            first_count_pin,
	output logic            second_count_pin,
	output logic            busy
);
	logic [7:0] left = 8'h00;
	logic [7:0] tick = 8'h00;
	logic       lvl  = 1'b1;
	initial busy = 1'b0;
	// idle high: the port latch bit is left at one
	assign first_count_pin  = sel ? 1'b1 : lvl;
	assign second_count_pin = sel ? lvl : 1'b1;
	always @(posedge ref_clk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			left <= edges;
			tick <= hold;
			lvl  <= 1'b0;
		end else if (busy && tick == 8'h01) begin
			// each level stands hold clocks, never under one machine cycle
			tick <= hold;
			lvl  <= ~lvl;
			if (!lvl) begin
				left <= left - 8'h01;
				if (left == 8'h01)
					busy <= 1'b0;
			end
		end else if (busy)
			tick <= tick - 8'h01;
	end
endmodule : dtc_pins

// ---- test/tb_dtc_top.sv ----
`timescale 1ns/1ns
`define CHK(n, e, g) n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("FAIL %s exp %h got %h", n, e, g); end
module tb_dtc_top;
	typedef struct {logic t; logic [1:0] m; logic [15:0] pre; int n;
		logic [15:0] ex; logic f;} dtc_row_t;
	dtc_row_t rows[7] = '{'{0, 2'h1, 16'hFFFE, 3, 16'h0001, 1}, '{0, 2'h0, 16'hFFFE, 3, 16'h00E1, 1},
		'{0, 2'h2, 16'h80FE, 3, 16'h8081, 1}, '{1, 2'h1, 16'h00FF, 2, 16'h0101, 0},
		'{1, 2'h3, 16'h1234, 5, 16'h1234, 0}, '{1, 2'h2, 16'h05FF, 1, 16'h0505, 1},
		'{1, 2'h0, 16'hFF1F, 1, 16'h0000, 1}};
	logic       ref_clk = 1'b0;
	logic       reset   = 1'b1;
	logic       sfr_wr  = 1'b0;
	logic       sfr_rd  = 1'b0;
	logic [7:0] sfr_addr  = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] rdata, md, gb, lo, hi;
	logic       g1 = 1'b0, g2 = 1'b0, ack1 = 1'b0, ack2 = 1'b0, go = 1'b0, sel = 1'b0;
	logic [7:0] hold = 8'h0C;
	wire  [7:0] sfr_rdata;
	wire        c1, c2, f1, f2, busy;
	int         mismatches = 0;
	int         n_tests = 0;

	always #10 ref_clk = ~ref_clk;

	dtc_top dut_u (.ref_clk(ref_clk), .reset(reset), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.first_count_pin(c1), .second_count_pin(c2), .first_gate_pin(g1),
		.second_gate_pin(g2), .first_vector_ack(ack1), .second_vector_ack(ack2),
		.first_overflow_flag(f1), .second_overflow_flag(f2));
	dtc_pins pins_u (.ref_clk(ref_clk), .go(go), .sel(sel), .edges(8'h05), .hold(hold),
		.first_count_pin(c1), .second_count_pin(c2), .busy(busy));

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk) #1;
		sfr_wr = 1'b1;
		sfr_addr = a;
		sfr_wdata = d;
		@(posedge ref_clk) #1;
		sfr_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk) #1;
		sfr_rd = 1'b1;
		sfr_addr = a;
		@(posedge ref_clk) #1;
		sfr_rd = 1'b0;
		rdata = sfr_rdata;
	endtask : rd

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		test_done();
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		#1 reset = 1'b0;
		rd(dtc_pkg::ADDR_TIMER_MODE);
		`CHK("mode reset", 8'h00, rdata)
		wr(8'h90, 8'hFF);
		rd(8'h90);
		`CHK("unmapped", 8'h00, rdata)
		wr(dtc_pkg::ADDR_TIMER_MODE, 8'hA5);
		rd(dtc_pkg::ADDR_TIMER_MODE);
		`CHK("mode rw", 8'hA5, rdata)
		// second timer gated with its pin low, first counts pin edges and sees none
		wr(dtc_pkg::ADDR_TIMER_CTL, 8'h50);
		rd(dtc_pkg::ADDR_TIMER_CTL);
		`CHK("run rw", 8'h50, rdata)
		// gate bit with gate pin low stops the count, so the run span is exact
		foreach (rows[i]) begin
			lo = 8'h8A + {7'h00, rows[i].t};
			hi = 8'h8C + {7'h00, rows[i].t};
			md = {6'h00, rows[i].m} << (rows[i].t ? 4 : 0);
			gb = rows[i].t ? 8'h80 : 8'h08;
			wr(dtc_pkg::ADDR_TIMER_MODE, md | gb);
			wr(lo, rows[i].pre[7:0]);
			wr(hi, rows[i].pre[15:8]);
			wr(dtc_pkg::ADDR_TIMER_CTL, rows[i].t ? 8'h40 : 8'h10);
			wr(dtc_pkg::ADDR_TIMER_MODE, md);
			repeat (12 * rows[i].n - 2) @(posedge ref_clk);
			wr(dtc_pkg::ADDR_TIMER_MODE, md | gb);
			repeat (3) @(posedge ref_clk);
			#1;
			`CHK("flag", rows[i].f, rows[i].t ? f2 : f1)
			rd(lo);
			`CHK("low", rows[i].ex[7:0], rdata)
			rd(hi);
			`CHK("high", rows[i].ex[15:8], rdata)
			rd(dtc_pkg::ADDR_TIMER_CTL);
			`CHK("ctl", {rows[i].f, 1'b1, 6'h00} >> (rows[i].t ? 0 : 2), rdata)
			ack1 = 1'b1;
			ack2 = 1'b1;
			@(posedge ref_clk) #1;
			ack1 = 1'b0;
			ack2 = 1'b0;
			`CHK("ack", 2'b00, {f2, f1})
			wr(dtc_pkg::ADDR_TIMER_CTL, 8'h00);
		end
		// pin edges at one and at two and a half machine cycles per level
		g1 = 1'b1;
		g2 = 1'b1;
		for (int i = 0; i < 4; i++) begin
			sel = i[0];
			hold = i[1] ? 8'h1E : 8'h0C;
			wr(dtc_pkg::ADDR_TIMER_MODE, 8'h0D << (sel ? 4 : 0));
			wr(8'h8A + {7'h00, sel}, 8'h00);
			wr(dtc_pkg::ADDR_TIMER_CTL, sel ? 8'h40 : 8'h10);
			go = 1'b1;
			@(posedge ref_clk) #1;
			go = 1'b0;
			for (int k = 0; k < 2000 && busy; k++) @(posedge ref_clk);
			repeat (30) @(posedge ref_clk);
			rd(8'h8A + {7'h00, sel});
			`CHK("edges", 8'h05, rdata)
			wr(dtc_pkg::ADDR_TIMER_CTL, 8'h00);
		end
		wr(dtc_pkg::ADDR_TIMER_MODE, 8'h03);
		wr(dtc_pkg::ADDR_FIRST_LOW, 8'h00);
		wr(dtc_pkg::ADDR_FIRST_HIGH, 8'hFF);
		wr(dtc_pkg::ADDR_TIMER_CTL, 8'h40);
		repeat (30) @(posedge ref_clk);
		#1;
		`CHK("split flags", 2'b10, {f2, f1})
		rd(dtc_pkg::ADDR_FIRST_LOW);
		`CHK("split low", 8'h00, rdata)
		ack2 = 1'b1;
		@(posedge ref_clk) #1;
		ack2 = 1'b0;
		`CHK("split ack", 1'b0, f2)
		reset = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 reset = 1'b0;
		rd(dtc_pkg::ADDR_TIMER_MODE);
		`CHK("mode rerun", 8'h00, rdata)
		test_done();
	end
endmodule : tb_dtc_top
